// [rtl/cmx_mixer.sv]
// module: two-path complex mixer with oscillators and i/q correction
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module cmx_mixer
    import cmx_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic [3:0]              i_addr,
    input  wire logic [31:0]             i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    input  wire logic [SYNC_W-1:0]       i_sync_pin,
    input  wire cmx_iq_type [NPATH-1:0]  i_smp,
    output logic [31:0]                  o_rdata,
    output cmx_iq_type [NPATH-1:0]       o_smp
);

    // ==================================================================
    // state
    typedef struct packed {
        cmx_pcfg_type [NPATH-1:0]           cfg;
        logic [SYNC_W-1:0]                  sync_src;
        logic                               mix_gain;
        logic                               soft_sync;
        logic [SYNC_W-1:0]                  sync_meta;
        logic [SYNC_W-1:0]                  sync_sy;
        logic [SYNC_W-1:0]                  sync_prev;
        logic [NPATH-1:0][ACC_W-1:0]        acc;
        logic [IDX_W-1:0]                   idx;
        cmx_iq_type [NPATH-1:0]             s1;
        logic [NPATH-1:0][ANG_W-1:0]        s1_ang;
        logic [NPATH-1:0]                   s1_use;
        logic [IDX_W-1:0]                   s1_idx;
        cmx_iq_type [NPATH-1:0]             s2;
        logic [IDX_W-1:0]                   s2_idx;
        cmx_iq_type [NPATH-1:0]             s3;
        cmx_iq_type [NPATH-1:0]             out;
        logic [31:0]                        rdata;
    } cmx_state_type;

    localparam cmx_state_type ST_RST = '{cfg: {PCFG_RST, PCFG_RST},
                                         default: '0};

    cmx_state_type          st_ff;
    cmx_state_type          nxt_st;
    cmx_iq_type [NPATH-1:0] rot;
    logic                   sync_evt;

    // ==================================================================
    // helpers
    function automatic logic [1:0] qsteps(input logic [CMIX_W-1:0] c);
        logic [1:0] q;
        q = {c[CMIX_B_FS2], 1'b0} + {1'b0, c[CMIX_B_FS4P]}
            + {c[CMIX_B_FS4N], c[CMIX_B_FS4N]};
        return q;
    endfunction

    function automatic cmx_iq_type qturn(input cmx_iq_type s,
                                         input logic [1:0] r);
        cmx_iq_type o;
        o = s;
        case (r)
            2'h0: o = s;
            2'h1: o = '{i: cmx_neg(s.q), q: s.i};
            2'h2: o = '{i: cmx_neg(s.i), q: cmx_neg(s.q)};
            2'h3: o = '{i: s.q, q: cmx_neg(s.i)};
            default: o = s;
        endcase
        return o;
    endfunction

    function automatic cmx_iq_type qmc(input cmx_iq_type s,
                                       input cmx_pcfg_type c);
        cmx_iq_type         o;
        logic signed [33:0] gi;
        logic signed [33:0] gq;
        logic signed [33:0] pp;
        gi  = 34'(s.i) * 34'($signed({1'b0, c.gain_i}));
        gq  = 34'(s.q) * 34'($signed({1'b0, c.gain_q}));
        pp  = 34'(s.q) * 34'($signed(c.phase));
        o.i = cmx_sat16((gi >>> GAIN_FRAC) + (pp >>> PHASE_FRAC));
        o.q = cmx_sat16(gq >>> GAIN_FRAC);
        return o;
    endfunction

    // ==================================================================
    // multipliers, one per path
    genvar gp;
    generate
        for (gp = 0; gp < NPATH; gp++) begin : g_rot
            cmx_rotator u_rot (
                .i_smp  (st_ff.s1[gp]),
                .i_ang  (st_ff.s1_ang[gp]),
                .i_use  (st_ff.s1_use[gp]),
                .i_gain (st_ff.mix_gain),
                .o_smp  (rot[gp])
            );
        end
    endgenerate

    // ==================================================================
    // next state
    always_comb begin
        logic [ANG_W-1:0] ang;
        logic [1:0]       r;
        ang    = '0;
        r      = '0;
        nxt_st = st_ff;
        // sync pins: two flops, then edge detect
        nxt_st.sync_meta = i_sync_pin;
        nxt_st.sync_sy   = st_ff.sync_meta;
        nxt_st.sync_prev = st_ff.sync_sy;
        sync_evt = st_ff.soft_sync
                   | (|(st_ff.sync_src & st_ff.sync_sy
                        & ~st_ff.sync_prev));
        nxt_st.soft_sync = 1'b0;
        nxt_st.rdata     = '0;

        // sample index for coarse and fs/8
        nxt_st.idx    = sync_evt ? '0 : st_ff.idx + 3'h1;
        nxt_st.s1_idx = st_ff.idx;
        nxt_st.s2_idx = st_ff.s1_idx;

        for (int p = 0; p < NPATH; p++) begin
            // oscillator
            if (sync_evt) begin
                nxt_st.acc[p] = '0;
            end else begin
                nxt_st.acc[p] = st_ff.acc[p] + st_ff.cfg[p].freq;
            end
            // angle: fine oscillator plus fixed fs/8 step
            ang = '0;
            if (st_ff.cfg[p].fine_en) begin
                ang = st_ff.acc[p][ACC_W-1 -: ANG_W]
                      + st_ff.cfg[p].poff;
            end
            if (st_ff.cfg[p].cmix[CMIX_B_FS8]) begin
                ang = ang + (ANG_W'(st_ff.idx) << FS8_SHIFT);
            end
            nxt_st.s1[p]     = i_smp[p];
            nxt_st.s1_ang[p] = ang;
            nxt_st.s1_use[p] = st_ff.cfg[p].fine_en
                               | st_ff.cfg[p].cmix[CMIX_B_FS8];
            nxt_st.s2[p]     = rot[p];
            // negate and swap by quarter turns per sample
            r = 2'(qsteps(st_ff.cfg[p].cmix) * st_ff.s2_idx[1:0]);
            nxt_st.s3[p]  = qturn(st_ff.s2[p], r);
            nxt_st.out[p] = qmc(st_ff.s3[p], st_ff.cfg[p]);
        end

        // register writes
        if (i_wr) begin
            case (i_addr)
                REG_FREQ_AB:  nxt_st.cfg[0].freq = i_wdata;
                REG_FREQ_CD:  nxt_st.cfg[1].freq = i_wdata;
                REG_POFF_AB:  nxt_st.cfg[0].poff = i_wdata[ANG_W-1:0];
                REG_POFF_CD:  nxt_st.cfg[1].poff = i_wdata[ANG_W-1:0];
                REG_CTRL: begin
                    nxt_st.sync_src =
                        i_wdata[CTRL_SYNC_LSB +: SYNC_W];
                    nxt_st.mix_gain       = i_wdata[CTRL_GAIN_BIT];
                    nxt_st.cfg[0].fine_en = i_wdata[CTRL_FINE_AB];
                    nxt_st.cfg[1].fine_en = i_wdata[CTRL_FINE_CD];
                    nxt_st.soft_sync      = i_wdata[CTRL_SOFT_SYNC];
                end
                REG_CMIX: begin
                    nxt_st.cfg[0].cmix = i_wdata[CMIX_AB_LSB +: CMIX_W];
                    nxt_st.cfg[1].cmix = i_wdata[CMIX_CD_LSB +: CMIX_W];
                end
                REG_GAIN_A: nxt_st.cfg[0].gain_i = i_wdata[GAIN_W-1:0];
                REG_GAIN_B: nxt_st.cfg[0].gain_q = i_wdata[GAIN_W-1:0];
                REG_GAIN_C: nxt_st.cfg[1].gain_i = i_wdata[GAIN_W-1:0];
                REG_GAIN_D: nxt_st.cfg[1].gain_q = i_wdata[GAIN_W-1:0];
                REG_PHASE_AB:
                    nxt_st.cfg[0].phase = i_wdata[PHASE_W-1:0];
                REG_PHASE_CD:
                    nxt_st.cfg[1].phase = i_wdata[PHASE_W-1:0];
                default: ;
            endcase
        end

        // register reads, data valid in the next cycle only
        if (i_rd) begin
            case (i_addr)
                REG_FREQ_AB:  nxt_st.rdata = st_ff.cfg[0].freq;
                REG_FREQ_CD:  nxt_st.rdata = st_ff.cfg[1].freq;
                REG_POFF_AB:  nxt_st.rdata = 32'(st_ff.cfg[0].poff);
                REG_POFF_CD:  nxt_st.rdata = 32'(st_ff.cfg[1].poff);
                REG_CTRL: begin
                    nxt_st.rdata[CTRL_SYNC_LSB +: SYNC_W] = st_ff.sync_src;
                    nxt_st.rdata[CTRL_GAIN_BIT] = st_ff.mix_gain;
                    nxt_st.rdata[CTRL_FINE_AB]  = st_ff.cfg[0].fine_en;
                    nxt_st.rdata[CTRL_FINE_CD]  = st_ff.cfg[1].fine_en;
                end
                REG_CMIX: begin
                    nxt_st.rdata[CMIX_AB_LSB +: CMIX_W] = st_ff.cfg[0].cmix;
                    nxt_st.rdata[CMIX_CD_LSB +: CMIX_W] = st_ff.cfg[1].cmix;
                end
                REG_GAIN_A:   nxt_st.rdata = 32'(st_ff.cfg[0].gain_i);
                REG_GAIN_B:   nxt_st.rdata = 32'(st_ff.cfg[0].gain_q);
                REG_GAIN_C:   nxt_st.rdata = 32'(st_ff.cfg[1].gain_i);
                REG_GAIN_D:   nxt_st.rdata = 32'(st_ff.cfg[1].gain_q);
                REG_PHASE_AB: nxt_st.rdata = 32'(st_ff.cfg[0].phase);
                REG_PHASE_CD: nxt_st.rdata = 32'(st_ff.cfg[1].phase);
                REG_ACC_AB:   nxt_st.rdata = st_ff.acc[0];
                REG_ACC_CD:   nxt_st.rdata = st_ff.acc[1];
                default:      nxt_st.rdata = '0;
            endcase
        end
    end

    // ==================================================================
    // registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata = st_ff.rdata;
    assign o_smp   = st_ff.out;

    // ==================================================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic byp1;
    assign byp1 = !st_ff.cfg[1].fine_en && st_ff.cfg[1].cmix == CMIX_OFF
                  && st_ff.cfg[1].gain_i == GAIN_RST
                  && st_ff.cfg[1].gain_q == GAIN_RST
                  && st_ff.cfg[1].phase == '0;

    property p_acc_step;
        !sync_evt |=> st_ff.acc[0] == $past(st_ff.acc[0])
                                      + $past(st_ff.cfg[0].freq);
    endproperty
    a_acc_step: assert property (p_acc_step)
        else $error("ab accumulator did not step by frequency word");

    property p_sync_clr;
        sync_evt |=> st_ff.acc == '0 && st_ff.idx == '0;
    endproperty
    a_sync_clr: assert property (p_sync_clr)
        else $error("sync did not clear accumulators");

    property p_acc_cd;
        !sync_evt ##1 !sync_evt |=> st_ff.acc[1] - $past(st_ff.acc[1])
                                    == $past(st_ff.cfg[1].freq);
    endproperty
    a_acc_cd: assert property (p_acc_cd)
        else $error("cd accumulator not on its own word");

    property p_mult_byp;
        !st_ff.s1_use[0] |=> st_ff.s2[0] == $past(st_ff.s1[0]);
    endproperty
    a_mult_byp: assert property (p_mult_byp)
        else $error("multiplier not bypassed");

    property p_fs2;
        st_ff.cfg[0].cmix == CMIX_FS2 && st_ff.s2_idx[0]
        |=> st_ff.s3[0].i == cmx_neg($past(st_ff.s2[0].i))
            && st_ff.s3[0].q == cmx_neg($past(st_ff.s2[0].q));
    endproperty
    a_fs2: assert property (p_fs2)
        else $error("fs/2 odd sample not negated");

    property p_fs4p;
        st_ff.cfg[0].cmix == CMIX_FS4P && st_ff.s2_idx[1:0] == 2'h1
        |=> st_ff.s3[0].i == cmx_neg($past(st_ff.s2[0].q))
            && st_ff.s3[0].q == $past(st_ff.s2[0].i);
    endproperty
    a_fs4p: assert property (p_fs4p)
        else $error("+fs/4 second sample wrong");

    property p_fs4n;
        st_ff.cfg[0].cmix == CMIX_FS4N && st_ff.s2_idx[1:0] == 2'h3
        |=> st_ff.s3[0].i == cmx_neg($past(st_ff.s2[0].q))
            && st_ff.s3[0].q == $past(st_ff.s2[0].i);
    endproperty
    a_fs4n: assert property (p_fs4n)
        else $error("-fs/4 fourth sample wrong");

    property p_e2e;
        (byp1 && !i_rst) ##1 byp1 [*4] |-> o_smp[1] == $past(i_smp[1], 4);
    endproperty
    a_e2e: assert property (p_e2e)
        else $error("bypass path not transparent after four cycles");

    property p_qmc;
        st_ff.cfg[0].gain_i == '0 && st_ff.cfg[0].gain_q == '0
        |=> st_ff.out[0].q == '0
            && st_ff.out[0].i == cmx_sat16(
                   (34'($past(st_ff.s3[0].q))
                    * 34'($signed($past(st_ff.cfg[0].phase))))
                   >>> PHASE_FRAC);
    endproperty
    a_qmc: assert property (p_qmc)
        else $error("phase term not added into i path");

    c_fs4:  cover property (st_ff.cfg[0].cmix == CMIX_FS4P
                            && st_ff.s2_idx[1:0] == 2'h3);
    c_sync: cover property (sync_evt ##1 st_ff.acc[0] == '0);
    c_fs8:  cover property (st_ff.cfg[1].fine_en
                            && st_ff.cfg[1].cmix[CMIX_B_FS8]);

endmodule

// [rtl/cmx_pkg.sv]
// package: constants, types and helpers for the complex mixer datapath
package cmx_pkg;

    // ==================================================================
    // widths
    localparam int NPATH   = 2;
    localparam int SMP_W   = 16;
    localparam int ACC_W   = 32;
    localparam int ANG_W   = 16;
    localparam int GAIN_W  = 11;
    localparam int PHASE_W = 12;
    localparam int SYNC_W  = 4;
    localparam int CMIX_W  = 4;
    localparam int IDX_W   = 3;

    // ==================================================================
    // register offsets
    localparam logic [3:0] REG_FREQ_AB  = 4'h0;
    localparam logic [3:0] REG_FREQ_CD  = 4'h1;
    localparam logic [3:0] REG_POFF_AB  = 4'h2;
    localparam logic [3:0] REG_POFF_CD  = 4'h3;
    localparam logic [3:0] REG_CTRL     = 4'h4;
    localparam logic [3:0] REG_CMIX     = 4'h5;
    localparam logic [3:0] REG_GAIN_A   = 4'h6;
    localparam logic [3:0] REG_GAIN_B   = 4'h7;
    localparam logic [3:0] REG_GAIN_C   = 4'h8;
    localparam logic [3:0] REG_GAIN_D   = 4'h9;
    localparam logic [3:0] REG_PHASE_AB = 4'hA;
    localparam logic [3:0] REG_PHASE_CD = 4'hB;
    localparam logic [3:0] REG_ACC_AB   = 4'hC;
    localparam logic [3:0] REG_ACC_CD   = 4'hD;

    // ==================================================================
    // field positions
    localparam int CTRL_SYNC_LSB  = 0;
    localparam int CTRL_GAIN_BIT  = 4;
    localparam int CTRL_FINE_AB   = 5;
    localparam int CTRL_FINE_CD   = 6;
    localparam int CTRL_SOFT_SYNC = 7;
    localparam int CMIX_AB_LSB    = 0;
    localparam int CMIX_CD_LSB    = 4;
    localparam int CMIX_B_FS8     = 3;
    localparam int CMIX_B_FS4P    = 2;
    localparam int CMIX_B_FS2     = 1;
    localparam int CMIX_B_FS4N    = 0;

    // ==================================================================
    // coarse codes, reset values, arithmetic constants
    localparam logic [3:0]  CMIX_OFF  = 4'h0;
    localparam logic [3:0]  CMIX_FS4N = 4'h1;
    localparam logic [3:0]  CMIX_FS2  = 4'h2;
    localparam logic [3:0]  CMIX_FS4P = 4'h4;
    localparam logic [3:0]  CMIX_FS8  = 4'h8;
    localparam logic [10:0] GAIN_RST  = 11'h400;
    localparam int GAIN_FRAC  = 10;
    localparam int PHASE_FRAC = 12;
    localparam int ROT_SH_ONE = 15;
    localparam int ROT_SH_HLF = 16;
    localparam int FS8_SHIFT  = 13;
    localparam int SIN_SH_A   = 13;
    localparam int SIN_FRAC   = 15;
    localparam logic [15:0] HALF_TURN = 16'h8000;
    localparam logic [15:0] QTR_TURN  = 16'h4000;
    localparam logic signed [33:0] SIN_K  = 34'sh0_0000_1CCD;
    localparam logic signed [33:0] SAT_HI = 34'sh0_0000_7FFF;
    localparam logic signed [33:0] SAT_LO = 34'sh3_FFFF_8000;

    // ==================================================================
    // types
    typedef logic signed [SMP_W-1:0] cmx_smp_type;

    typedef struct packed {
        cmx_smp_type i;
        cmx_smp_type q;
    } cmx_iq_type;

    typedef struct packed {
        logic [ACC_W-1:0]   freq;
        logic [ANG_W-1:0]   poff;
        logic [CMIX_W-1:0]  cmix;
        logic               fine_en;
        logic [GAIN_W-1:0]  gain_i;
        logic [GAIN_W-1:0]  gain_q;
        logic [PHASE_W-1:0] phase;
    } cmx_pcfg_type;

    localparam cmx_pcfg_type PCFG_RST = '{freq: '0, poff: '0, cmix: '0,
        fine_en: 1'b0, gain_i: GAIN_RST, gain_q: GAIN_RST, phase: '0};

    // ==================================================================
    // helpers
    function automatic cmx_smp_type cmx_sat16(input logic signed [33:0] v);
        if (v > SAT_HI) begin
            return SAT_HI[SMP_W-1:0];
        end else if (v < SAT_LO) begin
            return SAT_LO[SMP_W-1:0];
        end
        return v[SMP_W-1:0];
    endfunction

    function automatic cmx_smp_type cmx_neg(input cmx_smp_type x);
        return cmx_sat16(-34'(x));
    endfunction

endpackage

// [rtl/cmx_rotator.sv]
// module: sine and cosine generation and complex multiplier of one path
`timescale 1ns/10ps
module cmx_rotator
    import cmx_pkg::*;
(
    input  wire cmx_iq_type       i_smp,
    input  wire logic [ANG_W-1:0] i_ang,
    input  wire logic             i_use,
    input  wire logic             i_gain,
    output cmx_iq_type            o_smp
);

    // ==================================================================
    // parabolic sine with one correction step
    function automatic cmx_smp_type sine(input logic [ANG_W-1:0] a);
        logic [15:0]        w;
        logic [31:0]        p;
        logic signed [33:0] s;
        logic signed [33:0] ss;
        logic signed [33:0] t;
        logic signed [33:0] y;
        w  = HALF_TURN - {1'b0, a[14:0]};
        p  = 32'(a[14:0]) * 32'(w);
        s  = 34'(p >> SIN_SH_A);
        ss = s * s;
        t  = (ss >>> SIN_FRAC) - s;
        y  = s + ((t * SIN_K) >>> SIN_FRAC);
        return cmx_sat16(a[ANG_W-1] ? -y : y);
    endfunction

    // ==================================================================
    // rotation with gain select
    cmx_smp_type        cs;
    cmx_smp_type        sn;
    logic signed [33:0] ri;
    logic signed [33:0] rq;

    always_comb begin
        sn = sine(i_ang);
        cs = sine(i_ang + QTR_TURN);
        ri = 34'(i_smp.i) * 34'(cs) - 34'(i_smp.q) * 34'(sn);
        rq = 34'(i_smp.i) * 34'(sn) + 34'(i_smp.q) * 34'(cs);
        if (!i_use) begin
            o_smp = i_smp;
        end else if (i_gain) begin
            o_smp.i = cmx_sat16(ri >>> ROT_SH_ONE);
            o_smp.q = cmx_sat16(rq >>> ROT_SH_ONE);
        end else begin
            o_smp.i = cmx_sat16(ri >>> ROT_SH_HLF);
            o_smp.q = cmx_sat16(rq >>> ROT_SH_HLF);
        end
    end

endmodule

// [tb/cmx_src.sv]
// upstream sample source model for the mixer bench
`timescale 1ns/10ps
module cmx_src
    import cmx_pkg::*;
(
    input  wire logic              i_clk,
    output cmx_iq_type [NPATH-1:0] o_smp
);
    // ==========
    // random pairs, full-scale corner every 16th sample
    integer seed = 32'hdbc1_e6e4;
    int     n    = 0;
    initial o_smp = '0;
    always @(posedge i_clk) begin
        n <= n + 1;
        o_smp <= (n % 16 == 15) ? {4{16'h8000}}
                                : {$random(seed), $random(seed)};
    end
endmodule

// [tb/complex_mixer_nco_iq_correct_tb.sv]
// self-checking bench for the two-path complex mixer
`timescale 1ns/10ps
module complex_mixer_nco_iq_correct_tb
    import cmx_pkg::*;
;
    // ==========
    // stimulus and model state
    logic                   i_clk      = 1'b0;
    logic                   i_rst      = 1'b1;
    logic [3:0]             i_addr     = '0;
    logic [31:0]            i_wdata    = '0;
    logic                   i_wr       = 1'b0;
    logic                   i_rd       = 1'b0;
    logic [SYNC_W-1:0]      i_sync_pin = '0;
    logic [31:0]            o_rdata;
    cmx_iq_type [NPATH-1:0] i_smp, o_smp;
    cmx_iq_type [NPATH-1:0] hin [8];
    integer seed = 32'hdbc1_e6e4;
    int n_errors = 0, n_compared = 0, cyc = 0, tsync = 0, cmp_on = 0;
    int lastw, lastr, mg = 0;
    int cm [2] = '{0, 0}, fine [2] = '{0, 0}, pof [2] = '{0, 0};
    int gi [2] = '{1024, 1024}, gq [2] = '{1024, 1024}, ph [2] = '{0, 0};
    logic [3:0] ra [9] = '{6, 7, 8, 9, 4, 5, 0, 10, 14};
    int mt [8][6] = '{'{0, 2, 0, 1, 0, 0}, '{4, 1, 0, 0, 0, 0},
        '{1, 4, 0, 1, 0, 0}, '{8, 10, 0, 0, 0, 0}, '{12, 14, 0, 1, 0, 0},
        '{0, 0, 3, 1, 16384, 8192}, '{2, 8, 1, 0, 32768, 0},
        '{0, 8, 3, 0, 4096, 61440}};

    always #5 i_clk = ~i_clk;
    cmx_src u_src (.i_clk(i_clk), .o_smp(i_smp));
    cmx_mixer u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_sync_pin(i_sync_pin), .i_smp(i_smp), .o_rdata(o_rdata),
        .o_smp(o_smp));

    // ==========
    // compare, bus and model tasks
    task automatic conclude();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_smp(input cmx_smp_type got, input int exp, tol);
        n_compared++;
        if (^got === 1'bx || got - exp > tol || exp - got > tol) begin
            n_errors++;
            $display("ERROR t=%0t smp got %0d exp %0d", $time, got, exp);
        end
    endtask
    function automatic int sat(input int v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        lastw = cyc;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        lastr = cyc;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
        @(posedge i_clk);
    endtask
    task automatic model(input int p, input cmx_iq_type x, input int k);
        int i, q, t, r, b, tol;
        real th, s;
        i = x.i;
        q = x.q;
        b = cm[p];
        tol = 0;
        if (fine[p] || b[3]) begin
            th = (fine[p] ? pof[p] : 0) + (b[3] ? (k % 8) * 8192 : 0);
            th = th * 6.2831853 / 65536.0;
            s = mg ? 1.0 : 0.5;
            t = sat(int'((i * $cos(th) - q * $sin(th)) * s));
            q = sat(int'((i * $sin(th) + q * $cos(th)) * s));
            i = t;
            tol = 64;
        end
        r = ((2 * b[1] + b[2] + 3 * b[0]) * k) % 4;
        case (r)
            1: begin t = i; i = sat(-q); q = t; end
            2: begin i = sat(-i); q = sat(-q); end
            3: begin t = i; i = q; q = sat(-t); end
            default: ;
        endcase
        t = sat(((i * gi[p]) >>> 10) + ((q * ph[p]) >>> 12));
        cmp_smp(o_smp[p].i, t, tol);
        cmp_smp(o_smp[p].q, sat((q * gq[p]) >>> 10), tol);
    endtask
    task automatic cfg(input int c0, c1, f, g, p0, p1);
        cmp_on = 0;
        cm[0] = c0;
        cm[1] = c1;
        fine[0] = f & 1;
        fine[1] = f >> 1;
        mg = g;
        pof[0] = p0;
        pof[1] = p1;
        wr(REG_POFF_AB, 32'(p0));
        wr(REG_POFF_CD, 32'(p1));
        wr(REG_CMIX, 32'((c1 << 4) | c0));
        wr(REG_CTRL, 32'(128 | (f << 5) | (g << 4)));
        tsync = lastw + 2;
        repeat (12) @(posedge i_clk);
        cmp_on = 1;
        repeat (24) @(posedge i_clk);
        cmp_on = 0;
    endtask
    task automatic corr(input int p, input logic [31:0] a, b, c);
        gi[p] = a[10:0];
        gq[p] = b[10:0];
        ph[p] = $signed(c[11:0]);
        wr(p ? REG_GAIN_C : REG_GAIN_A, a);
        wr(p ? REG_GAIN_D : REG_GAIN_B, b);
        wr(p ? REG_PHASE_CD : REG_PHASE_AB, c);
    endtask

    // ==========
    // sample monitor against the model
    always @(negedge i_clk) begin
        hin[cyc % 8] = i_smp;
        if (cmp_on) begin
            for (int p = 0; p < NPATH; p++) begin
                model(p, hin[(cyc - 4) % 8][p], cyc - 4 - tsync);
            end
        end
        cyc <= cyc + 1;
    end

    // ==========
    // main sequence and watchdog
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    initial begin
        logic [31:0] d;
        int f1;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (ra[j]) begin
            rd(ra[j], d);
            chk(d, j < 4 ? 32'(GAIN_RST) : 32'h0);
        end
        wr(4'hF, 32'hffff_ffff);
        wr(REG_ACC_AB, 32'h1234);
        rd(REG_ACC_AB, d);
        chk(d, 32'h0);
        rd(4'hF, d);
        chk(d, 32'h0);
        f1 = ($random(seed) & 32'hffff) + 1;
        wr(REG_FREQ_AB, 32'(f1));
        wr(REG_FREQ_CD, 32'(3 * f1));
        wr(REG_CTRL, 32'h82);
        tsync = lastw + 2;
        rd(REG_ACC_AB, d);
        chk(d, 32'((lastr - tsync) * f1));
        rd(REG_ACC_CD, d);
        chk(d, 32'((lastr - tsync) * 3 * f1));
        repeat (30) @(posedge i_clk);
        i_sync_pin <= 4'h2;
        repeat (8) @(posedge i_clk);
        rd(REG_ACC_AB, d);
        chk(32'(d / f1 <= 8 && d % f1 == 0), 32'h1);
        i_sync_pin <= 4'h3;
        repeat (8) @(posedge i_clk);
        rd(REG_ACC_AB, d);
        chk(32'(d / f1 > 12), 32'h1);
        i_sync_pin <= 4'h0;
        wr(REG_FREQ_AB, 32'h0);
        wr(REG_FREQ_CD, 32'h0);
        foreach (mt[j]) begin
            cfg(mt[j][0], mt[j][1], mt[j][2], mt[j][3], mt[j][4],
                mt[j][5]);
        end
        corr(0, $random(seed), 32'h7ff, $random(seed));
        corr(1, $random(seed), $random(seed), 32'h800);
        rd(REG_GAIN_A, d);
        chk(d, 32'(gi[0]));
        cfg(0, 2, 0, 1, 0, 0);
        corr(0, 32'h0, 32'h0, $random(seed));
        cfg(4, 1, 0, 1, 0, 0);
        corr(0, 32'h5a8, 32'h5a8, 32'h0);
        corr(1, 32'h5a8, 32'h5a8, 32'h0);
        cfg(0, 0, 3, 0, 8192, 24576);
        conclude();
    end
endmodule
